// >>> breaker_failure_retrip_timing.sv
// Breaker-failure and retrip timing with pick-up modes, blocking and status.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "breaker_defs.svh"
module breaker_failure_retrip_timing #(
  parameter int TICK_CYCLES = int'(`STEP_TIME_US * `PS_PER_US / `CLK_PERIOD_PS)
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [15:0] PHASE_A_MAG,
  input wire logic [15:0] PHASE_B_MAG,
  input wire logic [15:0] PHASE_C_MAG,
  input wire logic [15:0] RESIDUAL_MAG,
  input wire logic BLOCK_IN,
  input wire logic TRIP_MONITOR_IN,
  input wire logic SIGNAL_MONITOR_IN,
  output logic START_OUT,
  output logic BLOCKED_OUT,
  output logic RETRIP_OUT,
  output logic BREAKER_FAILURE_OUTPUT,
  output logic [2:0] CONDITION
);
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic [19:0] tick_cnt_reg;
  logic retrip_en_reg;
  logic [2:0] mode_reg;
  logic res_en_reg;
  logic [18:0] retrip_dly_reg;
  logic [18:0] fail_dly_reg;
  logic [15:0] phase_thr_reg;
  logic [15:0] res_thr_reg;
  logic [18:0] retrip_cnt_reg;
  logic [18:0] retrip_cnt_next;
  logic [18:0] fail_cnt_reg;
  logic [18:0] fail_cnt_next;
  logic start_reg;
  logic blocked_reg;
  logic retrip_reg;
  logic retrip_next;
  logic fail_reg;
  logic fail_next;
  logic block_smp_reg;
  breaker_types_pkg::cond_type cond_reg;
  breaker_types_pkg::cond_type cond_next;
  logic [31:0] rdata_reg;
  logic [3:0] chan_active;
  logic pickup;
  logic run;

  // Pins from relays and the blocking matrix come from outside this clock.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else if (CE) begin
      pin_meta_reg <= {SIGNAL_MONITOR_IN, TRIP_MONITOR_IN, BLOCK_IN};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire block_now = pin_sync_reg[0];
  wire trip_now = pin_sync_reg[1];
  wire signal_now = pin_sync_reg[2];

  // One processing cycle per delay step, so every setting counts whole steps.
  wire tick = CE && (tick_cnt_reg == 20'h00000);
  wire [19:0] tick_reload = 20'(TICK_CYCLES - 1);

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      tick_cnt_reg <= 20'h00000;
    end else if (CE) begin
      tick_cnt_reg <= tick ? tick_reload : tick_cnt_reg - 20'h00001;
    end
  end

  pickup_hysteresis u_pickup (
    .clk(CORE_CLK),
    .rst(RST),
    .ce(CE),
    .mag({RESIDUAL_MAG, PHASE_C_MAG, PHASE_B_MAG, PHASE_A_MAG}),
    .phase_thr(phase_thr_reg),
    .res_thr(res_thr_reg),
    .res_en(res_en_reg),
    .active(chan_active)
  );

  wire current_pu = |chan_active;

  // In the AND modes pick-up follows current while counting waits for the
  // second condition; leaving it clears the counters rather than holding them.
  always_comb begin
    case (mode_reg)
      `MODE_CURRENT: begin
        pickup = current_pu;
        run = current_pu;
      end
      `MODE_DO: begin
        pickup = trip_now;
        run = trip_now;
      end
      `MODE_SIGNAL: begin
        pickup = signal_now;
        run = signal_now;
      end
      `MODE_CUR_AND_DO: begin
        pickup = current_pu;
        run = current_pu && trip_now;
      end
      `MODE_CUR_OR_DO: begin
        pickup = current_pu || trip_now;
        run = current_pu || trip_now;
      end
      `MODE_CUR_AND_SIG: begin
        pickup = current_pu;
        run = current_pu && signal_now;
      end
      `MODE_CUR_OR_SIG: begin
        pickup = current_pu || signal_now;
        run = current_pu || signal_now;
      end
      default: begin
        pickup = 1'b0;
        run = 1'b0;
      end
    endcase
  end

  // Decisions for a processing cycle all use the blocking level seen at its tick.
  wire go = pickup && !block_now;
  wire count = go && run;
  wire retrip_sat = &retrip_cnt_reg;
  wire fail_sat = &fail_cnt_reg;

  assign retrip_cnt_next = !count ? 19'h00000 :
                           retrip_sat ? retrip_cnt_reg : retrip_cnt_reg + 19'h00001;
  assign fail_cnt_next = !count ? 19'h00000 :
                         fail_sat ? fail_cnt_reg : fail_cnt_reg + 19'h00001;
  assign retrip_next = count && retrip_en_reg && (retrip_cnt_next >= retrip_dly_reg);
  assign fail_next = count && (fail_cnt_next >= fail_dly_reg);

  always_comb begin
    if (!pickup) begin
      cond_next = breaker_types_pkg::COND_NORMAL;
    end else if (block_now) begin
      cond_next = breaker_types_pkg::COND_BLOCKED;
    end else if (fail_next) begin
      cond_next = breaker_types_pkg::COND_FAIL;
    end else if (retrip_next) begin
      cond_next = breaker_types_pkg::COND_RETRIP;
    end else begin
      cond_next = breaker_types_pkg::COND_START;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      retrip_cnt_reg <= 19'h00000;
      fail_cnt_reg <= 19'h00000;
      start_reg <= 1'b0;
      blocked_reg <= 1'b0;
      retrip_reg <= 1'b0;
      fail_reg <= 1'b0;
      block_smp_reg <= 1'b0;
      cond_reg <= breaker_types_pkg::COND_NORMAL;
    end else if (tick) begin
      retrip_cnt_reg <= retrip_cnt_next;
      fail_cnt_reg <= fail_cnt_next;
      start_reg <= go;
      blocked_reg <= pickup && block_now;
      retrip_reg <= retrip_next;
      fail_reg <= fail_next;
      block_smp_reg <= block_now;
      cond_reg <= cond_next;
    end
  end

  // Settings may change while the function runs; they act from the next tick.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      retrip_en_reg <= 1'b1;
      mode_reg <= `MODE_CURRENT;
      res_en_reg <= 1'b0;
      retrip_dly_reg <= `RST_RETRIP_DELAY;
      fail_dly_reg <= `RST_FAIL_DELAY;
      phase_thr_reg <= `RST_PHASE_THR;
      res_thr_reg <= `RST_RES_THR;
    end else if (CE && WR) begin
      case (ADDR)
        `ADDR_CTRL: begin
          retrip_en_reg <= WDATA[`CTRL_RETRIP_EN];
          mode_reg <= WDATA[`CTRL_MODE_HI:`CTRL_MODE_LO];
          res_en_reg <= WDATA[`CTRL_RES_EN];
        end
        `ADDR_RETRIP_DELAY: begin
          retrip_dly_reg <= WDATA[18:0];
        end
        `ADDR_FAIL_DELAY: begin
          fail_dly_reg <= WDATA[18:0];
        end
        `ADDR_PHASE_THR: begin
          phase_thr_reg <= WDATA[15:0];
        end
        `ADDR_RES_THR: begin
          res_thr_reg <= WDATA[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  wire [31:0] ctrl_view = {27'h0000000, res_en_reg, mode_reg, retrip_en_reg};
  wire [31:0] status_view = {23'h000000, trip_now, block_smp_reg, blocked_reg,
                             fail_reg, retrip_reg, start_reg, 3'(cond_reg)};
  wire [31:0] read_mux =
    (ADDR == `ADDR_CTRL) ? ctrl_view :
    (ADDR == `ADDR_RETRIP_DELAY) ? {13'h0000, retrip_dly_reg} :
    (ADDR == `ADDR_FAIL_DELAY) ? {13'h0000, fail_dly_reg} :
    (ADDR == `ADDR_PHASE_THR) ? {16'h0000, phase_thr_reg} :
    (ADDR == `ADDR_RES_THR) ? {16'h0000, res_thr_reg} :
    (ADDR == `ADDR_STATUS) ? status_view : 32'h00000000;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rdata_reg <= 32'h00000000;
    end else if (CE) begin
      rdata_reg <= RD ? read_mux : 32'h00000000;
    end
  end

  assign RDATA = rdata_reg;
  assign START_OUT = start_reg;
  assign BLOCKED_OUT = blocked_reg;
  assign RETRIP_OUT = retrip_reg;
  assign BREAKER_FAILURE_OUTPUT = fail_reg;
  assign CONDITION = cond_reg;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  a_blocked_no_out: assert property (tick && pickup && block_now
    |=> blocked_reg && !start_reg && !retrip_reg && !fail_reg)
    else $error("Blocked pick-up still drove an output.");

  a_start_on_go: assert property (tick && pickup && !block_now
    |=> start_reg && !blocked_reg)
    else $error("Unblocked pick-up did not raise start.");

  a_block_clears_cnt: assert property (tick && start_reg && block_now
    |=> !start_reg && retrip_cnt_reg == 19'h00000 && fail_cnt_reg == 19'h00000)
    else $error("Blocking after start left counters running.");

  a_counters_together: assert property (retrip_cnt_reg == fail_cnt_reg)
    else $error("Retrip and breaker-failure counters diverged.");

  a_retrip_gated: assert property (tick && !retrip_en_reg |=> !retrip_reg)
    else $error("Retrip asserted while disabled.");

  a_retrip_timing: assert property (tick && count && retrip_en_reg &&
    (retrip_cnt_reg + 19'h00001 >= retrip_dly_reg) && !retrip_sat |=> retrip_reg)
    else $error("Retrip late after its delay.");

  a_retrip_not_early: assert property ($rose(retrip_reg)
    |-> retrip_cnt_reg >= retrip_dly_reg && retrip_cnt_reg != 19'h00000)
    else $error("Retrip earlier than its delay.");

  a_fail_timing: assert property ($rose(fail_reg)
    |-> fail_cnt_reg >= fail_dly_reg && ($past(start_reg) || $past(fail_dly_reg) <= 19'h00001))
    else $error("Breaker-failure output earlier than its delay.");

  a_and_mode_halt: assert property (tick && mode_reg == `MODE_CUR_AND_DO &&
    !trip_now |=> fail_cnt_reg == 19'h00000 && !retrip_reg && !fail_reg)
    else $error("Counting without the monitored trip in AND mode.");

  a_or_mode_hold: assert property (tick && mode_reg == `MODE_CUR_OR_DO &&
    !block_now && !current_pu && trip_now |=> start_reg)
    else $error("OR mode dropped pick-up while trip persisted.");

  a_clear_to_normal: assert property (tick && !pickup
    |=> cond_reg == breaker_types_pkg::COND_NORMAL && !start_reg && !retrip_reg && !fail_reg)
    else $error("Outputs survived a cleared pick-up.");

  a_status_read: assert property (RD && CE && ADDR == `ADDR_STATUS && !tick
    |=> RDATA[2:0] == 3'(cond_reg) && RDATA[`STAT_FAIL] == fail_reg)
    else $error("Status read did not show the condition state.");

  // Mode rules: counting follows the per-mode run term, checked on the clock cycle after the tick.
  a_cur_only_start: assert property (tick && mode_reg == `MODE_CURRENT &&
    current_pu && !block_now |=> start_reg)
    else $error("Current-only mode missed a current pick-up.");

  a_cur_only_clear: assert property (tick && mode_reg == `MODE_CURRENT &&
    !current_pu |=> retrip_cnt_reg == 19'h00000 && !retrip_reg && !fail_reg)
    else $error("Current-only mode kept counting below threshold.");

  a_and_mode_clear: assert property (tick && mode_reg == `MODE_CUR_AND_DO &&
    !current_pu |=> retrip_cnt_reg == 19'h00000 && !start_reg && !fail_reg)
    else $error("AND mode kept counting after the current dropped.");

  a_or_mode_count: assert property (tick && mode_reg == `MODE_CUR_OR_DO &&
    !block_now && (current_pu || trip_now) |=> retrip_cnt_reg != 19'h00000)
    else $error("OR mode did not count on current or trip.");

  a_or_mode_clear: assert property (tick && mode_reg == `MODE_CUR_OR_DO &&
    !current_pu && !trip_now |=> retrip_cnt_reg == 19'h00000 && !start_reg)
    else $error("OR mode kept counting with both conditions gone.");

  a_start_shown: assert property (start_reg |->
    cond_reg inside {breaker_types_pkg::COND_START, breaker_types_pkg::COND_RETRIP,
    breaker_types_pkg::COND_FAIL})
    else $error("Start shown with a wrong condition state.");

  a_blocked_shown: assert property (blocked_reg |->
    cond_reg == breaker_types_pkg::COND_BLOCKED && !start_reg)
    else $error("Blocked indication without the blocked condition.");

  a_fail_shown: assert property (fail_reg |->
    cond_reg == breaker_types_pkg::COND_FAIL && start_reg)
    else $error("Breaker-failure output without its condition state.");

  a_retrip_off_cond: assert property (tick && !retrip_en_reg |=>
    cond_reg != breaker_types_pkg::COND_RETRIP)
    else $error("Retrip condition shown while retrip is disabled.");

  a_block_sampled: assert property (tick |=> block_smp_reg == $past(block_now))
    else $error("Status blocking level differs from the tick sample.");

  // A low enable must hold every flop, the tick counter and read data included.
  a_ce_freeze: assert property (!CE |=> $stable(tick_cnt_reg) && $stable(cond_reg) &&
    $stable(retrip_cnt_reg) && $stable(chan_active) && $stable(RDATA))
    else $error("State moved while the clock enable was low.");

  a_rdata_idle: assert property (CE && !RD |=> RDATA == 32'h00000000)
    else $error("Read data stood outside the cycle after a read.");

  c_retrip_seen: cover property (tick && retrip_next && !retrip_reg);
  c_fail_seen: cover property (tick && fail_next && !fail_reg);
  c_blocked_start: cover property (tick && start_reg && block_now && pickup);
  c_and_halted: cover property (tick && mode_reg == `MODE_CUR_AND_DO && current_pu && !trip_now);
  c_or_held: cover property (tick && mode_reg == `MODE_CUR_OR_DO && !current_pu && trip_now);
endmodule

// >>> breaker_defs.svh
// Constants for the breaker-failure and retrip timing block.
// Operation
// - Blocking input is sampled once per processing cycle and used for that cycle.
// - Pick-up without blocking raises start and, outside the AND modes, runs both delay counters.
// - Pick-up with blocking raises blocked; no counting, no outputs.
// - Blocking after start clears start and counters as a pick-up drop would.
// - One pick-up starts the retrip and breaker-failure counters together.
// - Retrip enable, default on, gates the retrip output entirely.
// - Retrip asserts after continuous start for retrip delay, 5 ms steps, default 100 ms.
// - Breaker-failure asserts after continuous start for its delay, default 200 ms.
// - Current-only mode starts counters on phase or residual overcurrent alone.
// - Current-only mode clears counters once all currents fall below 97 % of threshold.
// - Current-and-trip mode picks up on current but counts only with trip active.
// - Current-and-trip mode raises retrip, then breaker-failure, while both persist.
// - Current-and-trip mode clears counters when current drops or trip releases.
// - Current-or-trip mode counts when current is high or trip is active.
// - Current-or-trip mode clears only when current is low and trip released.
// - Readable condition state: normal, start, retrip, breaker-failure or blocked.
// - Current pick-up sets above threshold, releases below 97 % of it.
// - Mode setting selects current, signal, trip output, or AND/OR combinations.
`ifndef BREAKER_DEFS_SVH
`define BREAKER_DEFS_SVH

`define CLK_PERIOD_PS 64'd5000
`define STEP_TIME_US 64'd5000
`define BLOCK_LEAD_US 64'd5000
`define PS_PER_US 64'd1000000

`define ADDR_CTRL 8'h00
`define ADDR_RETRIP_DELAY 8'h04
`define ADDR_FAIL_DELAY 8'h08
`define ADDR_PHASE_THR 8'h0C
`define ADDR_RES_THR 8'h10
`define ADDR_STATUS 8'h14

`define CTRL_RETRIP_EN 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 3
`define CTRL_RES_EN 4

`define MODE_CURRENT 3'h0
`define MODE_DO 3'h1
`define MODE_SIGNAL 3'h2
`define MODE_CUR_AND_DO 3'h3
`define MODE_CUR_OR_DO 3'h4
`define MODE_CUR_AND_SIG 3'h5
`define MODE_CUR_OR_SIG 3'h6

`define RST_RETRIP_DELAY 19'h00014
`define RST_FAIL_DELAY 19'h00028
`define RST_PHASE_THR 16'h00C8
`define RST_RES_THR 16'h04B0

`define STAT_START 3
`define STAT_RETRIP 4
`define STAT_FAIL 5
`define STAT_BLOCKED 6
`define STAT_BLOCK_IN 7
`define STAT_TRIP_IN 8

`define RESET_PCT 24'h000061
`define FULL_PCT 24'h000064

`endif

// >>> breaker_types_pkg.sv
// Types shared by the breaker-failure timing block.
package breaker_types_pkg;
  typedef enum logic [2:0] {
    COND_NORMAL,
    COND_START,
    COND_RETRIP,
    COND_FAIL,
    COND_BLOCKED
  } cond_type;
endpackage

// >>> pickup_hysteresis.sv
// Current pick-up comparators with release hysteresis, one per measured channel.
`timescale 1ns/100ps
`include "breaker_defs.svh"
module pickup_hysteresis (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [63:0] mag,
  input wire logic [15:0] phase_thr,
  input wire logic [15:0] res_thr,
  input wire logic res_en,
  output logic [3:0] active
);
  logic [3:0] active_reg;
  logic [3:0] active_next;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_chan
      wire [15:0] thr = (i < 3) ? phase_thr : res_thr;
      wire en = (i < 3) ? 1'b1 : res_en;
      wire [15:0] m = mag[16*i +: 16];
      wire above = m > thr;
      // Products keep the 97 % compare exact without division.
      wire below = ({8'h00, m} * `FULL_PCT) < ({8'h00, thr} * `RESET_PCT);
      // Between release and pick-up levels the channel holds its state.
      assign active_next[i] = !en ? 1'b0 :
                              above ? 1'b1 :
                              below ? 1'b0 : active_reg[i];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      active_reg <= 4'h0;
    end else if (ce) begin
      active_reg <= active_next;
    end
  end

  assign active = active_reg;

  a_release_hyst: assert property (@(posedge clk) disable iff (rst)
    ce && active_reg[0] && !(mag[15:0] > phase_thr) &&
    !(({8'h00, mag[15:0]} * `FULL_PCT) < ({8'h00, phase_thr} * `RESET_PCT))
    |=> active_reg[0])
    else $error("Phase pick-up released above the reset level.");
endmodule

// >>> current_trip_model.sv
// Model of the current measurement and the primary trip relay contact.
`timescale 1ns/100ps
module current_trip_model #(
  parameter int TRIP_LAG = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] fault_level,
  input wire logic [15:0] res_level,
  input wire logic trip_cmd,
  output logic [15:0] phase_a,
  output logic [15:0] phase_b,
  output logic [15:0] phase_c,
  output logic [15:0] residual,
  output logic trip_contact
);
  int lag_cnt;
  // A fault shows fully on phase A only, so a single-phase pick-up is exercised.
  assign phase_a = fault_level;
  assign phase_b = fault_level >> 1;
  assign phase_c = 16'h0010;
  assign residual = res_level;
  // The contact closes a few cycles after the command, like a real armature, and opens at once.
  always_ff @(posedge clk) begin
    if (rst || !trip_cmd) begin
      lag_cnt <= 0;
      trip_contact <= 1'b0;
    end else if (lag_cnt < TRIP_LAG) begin
      lag_cnt <= lag_cnt + 1;
    end else begin
      trip_contact <= 1'b1;
    end
  end
endmodule

// >>> test_breaker_failure_retrip_timing.sv
// Self-checking bench for the breaker-failure and retrip timing block.
`timescale 1ns/100ps
module test_breaker_failure_retrip_timing;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [15:0] fault = 16'h0000;
  logic [15:0] resl = 16'h0000;
  logic trip_cmd = 1'b0;
  logic sig = 1'b0;
  logic blk = 1'b0;
  logic ce = 1'b1;
  logic [15:0] pa, pb, pc, pres;
  logic trip, start, blocked, retrip, fail;
  logic [2:0] cond;
  logic [7:0] mask [3] = '{8'h7F, 8'h12, 8'h44};
  int fails = 0;
  int n_compared = 0;
  int p, m;

  always #2.5 core_clk = ~core_clk;

  current_trip_model feeder (.clk(core_clk), .rst(rst), .fault_level(fault), .res_level(resl),
    .trip_cmd(trip_cmd), .phase_a(pa), .phase_b(pb), .phase_c(pc), .residual(pres),
    .trip_contact(trip));

  // A tick every four cycles keeps each delay step short.
  breaker_failure_retrip_timing #(.TICK_CYCLES(4)) DUT (.CORE_CLK(core_clk), .RST(rst),
    .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .PHASE_A_MAG(pa), .PHASE_B_MAG(pb), .PHASE_C_MAG(pc), .RESIDUAL_MAG(pres),
    .BLOCK_IN(blk), .TRIP_MONITOR_IN(trip), .SIGNAL_MONITOR_IN(sig), .START_OUT(start),
    .BLOCKED_OUT(blocked), .RETRIP_OUT(retrip), .BREAKER_FAILURE_OUTPUT(fail),
    .CONDITION(cond));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    check("rdata", rdata, exp);
  endtask

  task automatic ticks(input int n);
    repeat (4 * n) @(posedge core_clk);
    #1;
  endtask

  // Order is start, blocked, retrip, breaker failure, condition.
  task automatic outs(input logic [6:0] exp);
    check("outputs", {25'h0, start, blocked, retrip, fail, cond}, {25'h0, exp});
  endtask

  // Leaves the bench just after the tick edge that raised start.
  task automatic wait_start();
    int i;
    for (i = 0; i < 40 && start !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (start !== 1'b1) begin
      fails++;
      $display("Error start expected 1 seen %b", start);
      results();
    end
  endtask

  task automatic results();
    $display("Compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk(8'h00, 32'h1);
    rd_chk(8'h04, 32'h14);
    rd_chk(8'h08, 32'h28);
    rd_chk(8'h0C, 32'hC8);
    rd_chk(8'h10, 32'h4B0);
    rd_chk(8'h14, 32'h0);
    rd_chk(8'h20, 32'h0);
    $display("Test register defaults done");
    wr_reg(8'h04, 32'h3);
    wr_reg(8'h08, 32'h6);
    fault <= 16'h00C9;
    wait_start();
    outs(7'h41);
    ticks(1);
    outs(7'h41);
    ticks(1);
    outs(7'h52);
    ticks(2);
    outs(7'h52);
    ticks(1);
    outs(7'h5B);
    rd_chk(8'h14, 32'h3B);
    @(posedge core_clk);
    fault <= 16'h00C3;
    ticks(3);
    outs(7'h5B);
    @(posedge core_clk);
    fault <= 16'h00C1;
    trip_cmd <= 1'b1;
    ticks(3);
    outs(7'h00);
    @(posedge core_clk);
    trip_cmd <= 1'b0;
    ticks(3);
    outs(7'h00);
    wr_reg(8'h00, 32'h11);
    resl <= 16'h04B1;
    wait_start();
    outs(7'h41);
    @(posedge core_clk);
    resl <= 16'h0000;
    blk <= 1'b1;
    ticks(3);
    outs(7'h00);
    $display("Test current only done");
    @(posedge core_clk);
    fault <= 16'h00C9;
    ticks(3);
    outs(7'h24);
    @(posedge core_clk);
    blk <= 1'b0;
    wait_start();
    @(posedge core_clk);
    blk <= 1'b1;
    ticks(2);
    outs(7'h24);
    @(posedge core_clk);
    blk <= 1'b0;
    wait_start();
    outs(7'h41);
    @(posedge core_clk);
    fault <= 16'h0000;
    $display("Test blocking done");
    ticks(2);
    wr_reg(8'h00, 32'h0);
    fault <= 16'h00C9;
    wait_start();
    ticks(2);
    outs(7'h41);
    ticks(3);
    outs(7'h4B);
    // With the clock enable low the outputs and the pick-up hold though the fault is gone.
    @(posedge core_clk);
    ce <= 1'b0;
    fault <= 16'h0000;
    ticks(3);
    outs(7'h4B);
    @(posedge core_clk);
    ce <= 1'b1;
    ticks(3);
    outs(7'h00);
    wr_reg(8'h00, 32'h7);
    fault <= 16'h00C9;
    ticks(4);
    check("retrip fail", {retrip, fail}, 32'h0);
    @(posedge core_clk);
    trip_cmd <= 1'b1;
    ticks(5);
    check("retrip fail", {retrip, fail}, 32'h2);
    ticks(3);
    outs(7'h5B);
    @(posedge core_clk);
    trip_cmd <= 1'b0;
    ticks(3);
    check("retrip fail", {retrip, fail}, 32'h0);
    @(posedge core_clk);
    fault <= 16'h0000;
    ticks(3);
    $display("Test current and trip done");
    wr_reg(8'h00, 32'h9);
    trip_cmd <= 1'b1;
    wait_start();
    outs(7'h41);
    ticks(1);
    @(posedge core_clk);
    fault <= 16'h00C9;
    trip_cmd <= 1'b0;
    ticks(1);
    outs(7'h52);
    @(posedge core_clk);
    fault <= 16'h0000;
    ticks(3);
    outs(7'h00);
    $display("Test current or trip done");
    for (p = 0; p < 3; p++) begin
      @(posedge core_clk);
      fault <= (p == 0) ? 16'h00C9 : 16'h0000;
      trip_cmd <= (p != 2);
      sig <= (p != 1);
      for (m = 0; m < 8; m++) begin
        wr_reg(8'h00, {28'h0, m[2:0], 1'b1});
        ticks(3);
        check("start", {31'h0, start}, {31'h0, mask[p][m]});
      end
    end
    wr_reg(8'h14, 32'hFFFFFFFF);
    rd_chk(8'h14, 32'h0);
    $display("Test mode table done");
    results();
  end
endmodule
